// ### poll_pkg.sv
// constants shared by the poll and parent-link manager
package poll_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_NS;
  localparam int TW = 20;
  localparam logic [19:0] POLL_MS = 20'h0_0064;
  localparam logic [19:0] FAST_POLL_MS = 20'h0_000A;
  localparam logic [19:0] BUTTON_MS = 20'h0_7530;
  localparam logic [1:0] MISS_LIMIT = 2'h3;
  localparam logic [1:0] REJOIN_TRIES = 2'h3;
  localparam logic [7:0] JOIN_OPEN = 8'hFF;
  localparam int NUM_TIMERS = 5;
  localparam int T_SLEEP = 0;
  localparam int T_HOLD = 1;
  localparam int T_POLL = 2;
  localparam int T_SAMPLE = 3;
  localparam int T_BUTTON = 4;
  typedef enum logic [2:0] {
    J_ORPHAN, J_ORPHAN_WAIT, J_PICK, J_REJOIN_SCAN, J_REJOIN_WAIT, J_ASSOC_WAIT, J_JOINED
  } join_state_t;
  typedef enum logic {P_SLEEP, P_AWAKE} pwr_state_t;
endpackage : poll_pkg

// ### timer_if.sv
// load and status signals of one millisecond timer
interface timer_if;
  logic load;
  logic stop;
  logic [19:0] value;
  logic busy;
  logic done;
  modport ctl (output load, output stop, output value, input busy, input done);
  modport tmr (input load, input stop, input value, output busy, output done);
endinterface : timer_if

// ### ms_tick_gen.sv
// millisecond enable pulse from the system clock
module ms_tick_gen #(
  parameter int unsigned MS_CYCLES = poll_pkg::MS_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  output logic tick
);
  logic [31:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 32'h0000_0001;
    if (cnt_reg >= 32'(MS_CYCLES - 1)) begin
      cnt_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : ms_tick_gen

// ### ms_timer.sv
// one-shot down counter in millisecond steps
module ms_timer (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic tick,
  timer_if.tmr t
);
  logic [19:0] count_reg, count_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (t.stop) begin
      busy_next = 1'b0;
    end else if (t.load) begin
      // a zero load expires at once instead of wrapping
      count_next = t.value;
      busy_next = (t.value != 20'h0_0000);
      done_next = (t.value == 20'h0_0000);
    end else if (busy_reg && tick) begin
      count_next = count_reg - 20'h0_0001;
      if (count_reg == 20'h0_0001) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      count_reg <= 20'h0_0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign t.busy = busy_reg;
  assign t.done = done_reg;
endmodule : ms_timer

// ### end_device_poll_parent_manager.sv
// sleep/wake poll scheduler and parent-link manager of an end device
// How it works
// - pin sleep: poll every 100ms while pin low
// - cyclic sleep: one poll, then sleep unless held
// - hold timer running: poll every 100 ms
// - parent data received: poll again quickly
// - data stops: back to 100 ms polling
// - sampling needs nonzero interval and enabled line
// - wake sample sent, hold timer started
// - samples repeat at interval until hold expires
// - button falling edge keeps device awake 30s
// - three missed poll acks: parent lost
// - orphan scan after power-up or reset
// - no orphan reply: search new parent
// - frames go to parent, await its ack
// - join window below FFh: rejoin first
// - repeated rejoin failure or FFh: associate
// - rejoin request only to matching network id
// - serial or radio data restarts hold timer
// - hold timer expiry returns device to sleep
// - sleep period counts in 10ms units
// - hold and sample interval count in 1ms
module end_device_poll_parent_manager #(
  parameter int unsigned MS_CYCLES = poll_pkg::MS_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PIN_SLEEP_MODE,
  input wire logic SLEEP_REQUEST_PIN,
  input wire logic [15:0] SLEEP_PERIOD_SETTING,
  input wire logic [15:0] WAKE_HOLD_TIMER,
  input wire logic [15:0] SAMPLE_INTERVAL_SETTING,
  input wire logic [7:0] JOIN_WINDOW_SETTING,
  input wire logic [9:0] IO_LINE_ENABLES,
  input wire logic [4:0] EXTRA_IO_LINE_ENABLES,
  input wire logic COMMISSIONING_PIN_CONFIG,
  input wire logic COMMISSIONING_INPUT_PIN,
  input wire logic SERIAL_DATA_RX,
  input wire logic RADIO_DATA_RX,
  input wire logic POLL_ACK,
  input wire logic POLL_NOACK,
  input wire logic TX_DATA_REQ,
  input wire logic TX_ACK,
  input wire logic ORPHAN_RESP,
  input wire logic ORPHAN_FAIL,
  input wire logic [63:0] OWN_PAN_ID,
  input wire logic [63:0] SCAN_PAN_ID,
  input wire logic SCAN_VALID,
  input wire logic SCAN_DONE,
  input wire logic REJOIN_RESP,
  input wire logic REJOIN_FAIL,
  input wire logic ASSOC_DONE,
  input wire logic ASSOC_FAIL,
  output logic AWAKE,
  output logic JOINED,
  output logic POLL_REQ,
  output logic SAMPLE_SEND,
  output logic TX_FRAME,
  output logic TX_DONE,
  output logic ORPHAN_SCAN,
  output logic REJOIN_SCAN,
  output logic REJOIN_REQ,
  output logic ASSOC_REQ,
  output logic PARENT_LOST
);
  logic ms_tick;
  logic [4:0] t_load, t_stop, t_busy, t_done;
  logic [19:0] t_val [5];
  timer_if tif [5] ();

  ms_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .MCLK(MCLK),
    .RST(RST),
    .tick(ms_tick)
  );

  generate
    for (genvar i = 0; i < poll_pkg::NUM_TIMERS; i++) begin : g_timer
      ms_timer u_timer (
        .MCLK(MCLK),
        .RST(RST),
        .tick(ms_tick),
        .t(tif[i])
      );
      assign tif[i].load = t_load[i];
      assign tif[i].stop = t_stop[i];
      assign tif[i].value = t_val[i];
      assign t_busy[i] = tif[i].busy;
      assign t_done[i] = tif[i].done;
    end
  endgenerate

  // join group
  poll_pkg::join_state_t join_reg, join_next;
  logic [1:0] tries_reg, tries_next;
  logic joined_reg, joined_next;
  logic orphan_reg, orphan_next;
  logic scan_reg, scan_next;
  logic rejoin_reg, rejoin_next;
  logic assoc_reg, assoc_next;
  logic lost_reg, lost_next;
  logic parent_lost;

  always_comb begin
    join_next = join_reg;
    tries_next = tries_reg;
    orphan_next = 1'b0;
    scan_next = 1'b0;
    rejoin_next = 1'b0;
    assoc_next = 1'b0;
    lost_next = 1'b0;
    case (join_reg)
      poll_pkg::J_ORPHAN: begin
        orphan_next = 1'b1;
        join_next = poll_pkg::J_ORPHAN_WAIT;
      end
      poll_pkg::J_ORPHAN_WAIT: begin
        if (ORPHAN_RESP) begin
          join_next = poll_pkg::J_JOINED;
        end else if (ORPHAN_FAIL) begin
          join_next = poll_pkg::J_PICK;
        end
      end
      poll_pkg::J_PICK: begin
        if (JOIN_WINDOW_SETTING == poll_pkg::JOIN_OPEN || tries_reg >= poll_pkg::REJOIN_TRIES) begin
          assoc_next = 1'b1;
          join_next = poll_pkg::J_ASSOC_WAIT;
        end else begin
          scan_next = 1'b1;
          join_next = poll_pkg::J_REJOIN_SCAN;
        end
      end
      poll_pkg::J_REJOIN_SCAN: begin
        if (SCAN_VALID && SCAN_PAN_ID == OWN_PAN_ID) begin
          rejoin_next = 1'b1;
          join_next = poll_pkg::J_REJOIN_WAIT;
        end else if (SCAN_DONE) begin
          tries_next = 2'(tries_reg + 2'h1);
          join_next = poll_pkg::J_PICK;
        end
      end
      poll_pkg::J_REJOIN_WAIT: begin
        if (REJOIN_RESP) begin
          tries_next = 2'h0;
          join_next = poll_pkg::J_JOINED;
        end else if (REJOIN_FAIL) begin
          tries_next = 2'(tries_reg + 2'h1);
          join_next = poll_pkg::J_PICK;
        end
      end
      poll_pkg::J_ASSOC_WAIT: begin
        if (ASSOC_DONE) begin
          tries_next = 2'h0;
          join_next = poll_pkg::J_JOINED;
        end else if (ASSOC_FAIL) begin
          join_next = poll_pkg::J_PICK;
        end
      end
      poll_pkg::J_JOINED: begin
        if (parent_lost) begin
          lost_next = 1'b1;
          tries_next = 2'h0;
          join_next = poll_pkg::J_PICK;
        end
      end
      default: begin
        join_next = poll_pkg::J_ORPHAN;
      end
    endcase
    joined_next = (join_next == poll_pkg::J_JOINED);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      join_reg <= poll_pkg::J_ORPHAN;
      tries_reg <= 2'h0;
      joined_reg <= 1'b0;
      orphan_reg <= 1'b0;
      scan_reg <= 1'b0;
      rejoin_reg <= 1'b0;
      assoc_reg <= 1'b0;
      lost_reg <= 1'b0;
    end else begin
      join_reg <= join_next;
      tries_reg <= tries_next;
      joined_reg <= joined_next;
      orphan_reg <= orphan_next;
      scan_reg <= scan_next;
      rejoin_reg <= rejoin_next;
      assoc_reg <= assoc_next;
      lost_reg <= lost_next;
    end
  end

  // power and poll group
  poll_pkg::pwr_state_t pwr_reg, pwr_next;
  logic [1:0] miss_reg, miss_next;
  logic poll_wait_reg, poll_wait_next;
  logic fast_reg, fast_next;
  logic rx_reg, rx_next;
  logic poll_reg, poll_next;
  logic sample_reg, sample_next;
  logic tx_frame_reg, tx_frame_next;
  logic tx_wait_reg, tx_wait_next;
  logic tx_done_reg, tx_done_next;
  logic btn_prev_reg, btn_prev_next;
  logic awake_reg, awake_next;
  logic btn_fall, samp_en, pin_awake, answer, stay, data_in;

  always_comb begin
    pwr_next = pwr_reg;
    miss_next = miss_reg;
    poll_wait_next = poll_wait_reg;
    fast_next = fast_reg;
    rx_next = rx_reg;
    poll_next = 1'b0;
    sample_next = 1'b0;
    tx_frame_next = 1'b0;
    tx_wait_next = tx_wait_reg;
    tx_done_next = 1'b0;
    parent_lost = 1'b0;
    t_load = 5'h00;
    t_stop = 5'h00;
    btn_prev_next = COMMISSIONING_INPUT_PIN;
    btn_fall = COMMISSIONING_PIN_CONFIG && btn_prev_reg && !COMMISSIONING_INPUT_PIN;
    samp_en = (SAMPLE_INTERVAL_SETTING != 16'h0000) && ((|IO_LINE_ENABLES) || (|EXTRA_IO_LINE_ENABLES));
    pin_awake = PIN_SLEEP_MODE && !SLEEP_REQUEST_PIN;
    data_in = SERIAL_DATA_RX || RADIO_DATA_RX;
    answer = poll_wait_reg && (POLL_ACK || POLL_NOACK);
    stay = 1'b0;
    if (btn_fall) begin
      t_load[poll_pkg::T_BUTTON] = 1'b1;
    end
    if (tx_wait_reg && TX_ACK) begin
      tx_wait_next = 1'b0;
      tx_done_next = 1'b1;
    end else if (TX_DATA_REQ && pwr_reg == poll_pkg::P_AWAKE && joined_reg && !tx_wait_reg) begin
      tx_frame_next = 1'b1;
      tx_wait_next = 1'b1;
    end
    if (!joined_reg) begin
      // no parent to poll while searching; stay up
      pwr_next = poll_pkg::P_AWAKE;
      poll_wait_next = 1'b0;
      miss_next = 2'h0;
      fast_next = 1'b0;
      rx_next = 1'b0;
      tx_wait_next = 1'b0;
      t_stop = 5'h0F;
    end else begin
      case (pwr_reg)
        poll_pkg::P_SLEEP: begin
          if ((PIN_SLEEP_MODE ? !SLEEP_REQUEST_PIN : t_done[poll_pkg::T_SLEEP]) || btn_fall) begin
            pwr_next = poll_pkg::P_AWAKE;
            poll_next = 1'b1;
            poll_wait_next = 1'b1;
            rx_next = 1'b0;
            if (samp_en) begin
              sample_next = 1'b1;
              t_load[poll_pkg::T_HOLD] = 1'b1;
              t_load[poll_pkg::T_SAMPLE] = 1'b1;
            end
          end
        end
        poll_pkg::P_AWAKE: begin
          if (data_in) begin
            t_load[poll_pkg::T_HOLD] = 1'b1;
          end
          if (RADIO_DATA_RX) begin
            rx_next = 1'b1;
          end
          if (samp_en && t_done[poll_pkg::T_SAMPLE] && t_busy[poll_pkg::T_HOLD]) begin
            sample_next = 1'b1;
            t_load[poll_pkg::T_SAMPLE] = 1'b1;
          end
          if (answer) begin
            poll_wait_next = 1'b0;
            fast_next = rx_reg || RADIO_DATA_RX;
            rx_next = 1'b0;
            if (POLL_ACK) begin
              miss_next = 2'h0;
            end else if (miss_reg == 2'(poll_pkg::MISS_LIMIT - 2'h1)) begin
              miss_next = 2'h0;
              parent_lost = 1'b1;
            end else begin
              miss_next = 2'(miss_reg + 2'h1);
            end
          end
          stay = t_busy[poll_pkg::T_HOLD] || t_load[poll_pkg::T_HOLD] || t_busy[poll_pkg::T_BUTTON] ||
                 t_load[poll_pkg::T_BUTTON] || pin_awake || tx_wait_next || fast_next;
          if (!poll_wait_next && !stay) begin
            // a poll in flight is always finished before sleeping
            pwr_next = poll_pkg::P_SLEEP;
            fast_next = 1'b0;
            t_stop[poll_pkg::T_HOLD] = 1'b1;
            t_stop[poll_pkg::T_POLL] = 1'b1;
            t_stop[poll_pkg::T_SAMPLE] = 1'b1;
            t_load[poll_pkg::T_SLEEP] = !PIN_SLEEP_MODE;
          end else if (answer) begin
            t_load[poll_pkg::T_POLL] = 1'b1;
          end else if (!t_busy[poll_pkg::T_POLL] && !poll_wait_reg) begin // an expired or idle poll timer issues the next poll, also after a rejoin
            poll_next = 1'b1;
            poll_wait_next = 1'b1;
          end
        end
        default: begin
          pwr_next = poll_pkg::P_AWAKE;
        end
      endcase
    end
    awake_next = (pwr_next == poll_pkg::P_AWAKE);
  end

  always_comb begin
    t_val[poll_pkg::T_SLEEP] = {1'b0, SLEEP_PERIOD_SETTING, 3'b000} + {3'b000, SLEEP_PERIOD_SETTING, 1'b0};
    t_val[poll_pkg::T_HOLD] = {4'h0, WAKE_HOLD_TIMER};
    t_val[poll_pkg::T_POLL] = fast_next ? poll_pkg::FAST_POLL_MS : poll_pkg::POLL_MS;
    t_val[poll_pkg::T_SAMPLE] = {4'h0, SAMPLE_INTERVAL_SETTING};
    t_val[poll_pkg::T_BUTTON] = poll_pkg::BUTTON_MS;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pwr_reg <= poll_pkg::P_AWAKE;
      miss_reg <= 2'h0;
      poll_wait_reg <= 1'b0;
      fast_reg <= 1'b0;
      rx_reg <= 1'b0;
      poll_reg <= 1'b0;
      sample_reg <= 1'b0;
      tx_frame_reg <= 1'b0;
      tx_wait_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      btn_prev_reg <= 1'b1;
      awake_reg <= 1'b1;
    end else begin
      pwr_reg <= pwr_next;
      miss_reg <= miss_next;
      poll_wait_reg <= poll_wait_next;
      fast_reg <= fast_next;
      rx_reg <= rx_next;
      poll_reg <= poll_next;
      sample_reg <= sample_next;
      tx_frame_reg <= tx_frame_next;
      tx_wait_reg <= tx_wait_next;
      tx_done_reg <= tx_done_next;
      btn_prev_reg <= btn_prev_next;
      awake_reg <= awake_next;
    end
  end

  assign AWAKE = awake_reg;
  assign JOINED = joined_reg;
  assign POLL_REQ = poll_reg;
  assign SAMPLE_SEND = sample_reg;
  assign TX_FRAME = tx_frame_reg;
  assign TX_DONE = tx_done_reg;
  assign ORPHAN_SCAN = orphan_reg;
  assign REJOIN_SCAN = scan_reg;
  assign REJOIN_REQ = rejoin_reg;
  assign ASSOC_REQ = assoc_reg;
  assign PARENT_LOST = lost_reg;
endmodule : end_device_poll_parent_manager

// ### poll_mgr_sva.sv
// port-level checker of the poll and parent-link manager
module poll_mgr_sva (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [15:0] SAMPLE_INTERVAL_SETTING,
  input wire logic [7:0] JOIN_WINDOW_SETTING,
  input wire logic [9:0] IO_LINE_ENABLES,
  input wire logic [4:0] EXTRA_IO_LINE_ENABLES,
  input wire logic COMMISSIONING_PIN_CONFIG,
  input wire logic COMMISSIONING_INPUT_PIN,
  input wire logic POLL_ACK,
  input wire logic POLL_NOACK,
  input wire logic TX_ACK,
  input wire logic ORPHAN_FAIL,
  input wire logic [63:0] OWN_PAN_ID,
  input wire logic [63:0] SCAN_PAN_ID,
  input wire logic SCAN_VALID,
  input wire logic AWAKE,
  input wire logic JOINED,
  input wire logic TX_DONE,
  input wire logic ORPHAN_SCAN,
  input wire logic REJOIN_SCAN,
  input wire logic REJOIN_REQ,
  input wire logic ASSOC_REQ,
  input wire logic SAMPLE_SEND,
  input wire logic PARENT_LOST
);
  logic [1:0] miss_reg;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // misses since the last acked poll; a loss restarts the count
  always_ff @(posedge MCLK) begin
    if (RST || POLL_ACK || PARENT_LOST) miss_reg <= 2'h0;
    else if (POLL_NOACK) miss_reg <= miss_reg + 2'h1;
  end
  property p_orphan; $fell(RST) |-> ##[0:1] ORPHAN_SCAN; endproperty
  property p_orphan_fail; ORPHAN_FAIL |-> ##[1:4] (REJOIN_SCAN || ASSOC_REQ); endproperty
  property p_window; REJOIN_SCAN |-> JOIN_WINDOW_SETTING != poll_pkg::JOIN_OPEN; endproperty
  property p_pan; REJOIN_REQ |-> $past(SCAN_VALID) && $past(SCAN_PAN_ID) == $past(OWN_PAN_ID); endproperty
  property p_tx; TX_DONE |-> $past(TX_ACK); endproperty
  property p_sample;
    SAMPLE_SEND |-> SAMPLE_INTERVAL_SETTING != 16'h0000 && (|{IO_LINE_ENABLES, EXTRA_IO_LINE_ENABLES});
  endproperty
  property p_button;
    COMMISSIONING_PIN_CONFIG && $fell(COMMISSIONING_INPUT_PIN) && JOINED |-> ##[1:3] AWAKE [*8];
  endproperty
  property p_lost; PARENT_LOST |-> miss_reg == 2'h3 && !JOINED; endproperty
  property p_third; POLL_NOACK && miss_reg == 2'h2 |-> ##1 PARENT_LOST; endproperty
  a_orphan: assert property (p_orphan) else $error("no orphan scan after reset");
  a_orphan_fail: assert property (p_orphan_fail) else $error("no parent search after orphan failure");
  a_window: assert property (p_window) else $error("rejoin with open join window");
  a_pan: assert property (p_pan) else $error("rejoin request to foreign network");
  a_tx: assert property (p_tx) else $error("transfer done without parent ack");
  a_sample: assert property (p_sample) else $error("sample sent while sampling disabled");
  a_button: assert property (p_button) else $error("button edge did not keep device awake");
  a_lost: assert property (p_lost) else $error("parent lost without three misses");
  a_third: assert property (p_third) else $error("third miss did not drop parent");
  c_join: cover property ($rose(JOINED));
  c_lost: cover property (PARENT_LOST);
  c_sample: cover property (SAMPLE_SEND && AWAKE);
endmodule : poll_mgr_sva

bind end_device_poll_parent_manager poll_mgr_sva chk (.*);

// ### parent_model.sv
// parent router model on the far side of the radio link
module parent_model #(
  parameter int MS = 10
) (
  input wire logic MCLK,
  input wire logic POLL_REQ,
  input wire logic TX_FRAME,
  input wire logic ORPHAN_SCAN,
  input wire logic REJOIN_SCAN,
  input wire logic REJOIN_REQ,
  input wire logic ASSOC_REQ,
  input wire logic [15:0] SLEEP_PERIOD_SETTING,
  input wire logic [63:0] OWN_PAN_ID,
  output logic POLL_ACK,
  output logic POLL_NOACK,
  output logic RADIO_DATA_RX,
  output logic TX_ACK,
  output logic ORPHAN_RESP,
  output logic ORPHAN_FAIL,
  output logic [63:0] SCAN_PAN_ID,
  output logic SCAN_VALID,
  output logic SCAN_DONE,
  output logic REJOIN_RESP,
  output logic REJOIN_FAIL,
  output logic ASSOC_DONE,
  output logic ASSOC_FAIL
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drop = 0, orphan_ok = 0, full = 0;
  int pend = 0, dly = 3, age = 0;
  initial {POLL_ACK, POLL_NOACK, RADIO_DATA_RX, TX_ACK, ORPHAN_RESP, ORPHAN_FAIL, SCAN_PAN_ID, SCAN_VALID,
    SCAN_DONE, REJOIN_RESP, REJOIN_FAIL, ASSOC_DONE, ASSOC_FAIL} = '0;
  task automatic pulse(ref logic s, input int d);
    repeat (d) @(negedge MCLK);
    s = 1'b1;
    @(negedge MCLK);
    s = 1'b0;
  endtask : pulse
  function automatic int buf_cycles();
    int ms;
    ms = 12 * SLEEP_PERIOD_SETTING;
    ms = ms < 1200 ? 1200 : ms > 30000 ? 30000 : ms;
    return ms * MS;
  endfunction : buf_cycles
  // held frames age only while the child stays silent
  always @(posedge MCLK) begin
    age = (pend == 0 || POLL_REQ === 1'b1) ? 0 : age + 1;
    if (age > buf_cycles()) pend = 0;
  end
  // held data goes ahead of the ack, while the child still listens
  always @(posedge MCLK) if (POLL_REQ === 1'b1) begin
    if (drop) pulse(POLL_NOACK, dly);
    else if (pend > 0) begin
      pend--;
      pulse(RADIO_DATA_RX, 1);
      pulse(POLL_ACK, 1);
    end else pulse(POLL_ACK, dly);
  end
  // status waits for route discovery, hence the long delay
  always @(posedge MCLK) if (TX_FRAME === 1'b1) pulse(TX_ACK, dly + 20);
  always @(posedge MCLK) if (ORPHAN_SCAN === 1'b1) begin
    if (orphan_ok) pulse(ORPHAN_RESP, 1);
    else pulse(ORPHAN_FAIL, 1);
  end
  // a foreign network first, so a careless device answers it
  always @(posedge MCLK) if (REJOIN_SCAN === 1'b1) begin
    @(negedge MCLK);
    SCAN_PAN_ID = ~OWN_PAN_ID;
    pulse(SCAN_VALID, 1);
    SCAN_PAN_ID = OWN_PAN_ID;
    pulse(SCAN_VALID, 1);
    SCAN_PAN_ID = ~OWN_PAN_ID;
    pulse(SCAN_DONE, 1);
  end
  always @(posedge MCLK) if (REJOIN_REQ === 1'b1) begin
    if (full) pulse(REJOIN_FAIL, 2);
    else pulse(REJOIN_RESP, 2);
  end
  always @(posedge MCLK) if (ASSOC_REQ === 1'b1) pulse(ASSOC_DONE, 2);
endmodule : parent_model

// ### end_device_poll_parent_manager_tb_top.sv
// self-checking bench of the poll and parent-link manager
module end_device_poll_parent_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, RST = 1, PIN_SLEEP_MODE = 0, SLEEP_REQUEST_PIN = 1, COMMISSIONING_PIN_CONFIG = 0;
  logic COMMISSIONING_INPUT_PIN = 1, SERIAL_DATA_RX = 0, TX_DATA_REQ = 0;
  logic [15:0] SLEEP_PERIOD_SETTING = 16'h0001, WAKE_HOLD_TIMER = 16'h00C8, SAMPLE_INTERVAL_SETTING = 16'h0000;
  logic [7:0] JOIN_WINDOW_SETTING = 8'h00;
  logic [9:0] IO_LINE_ENABLES = 10'h000;
  logic [4:0] EXTRA_IO_LINE_ENABLES = 5'h00;
  logic [63:0] OWN_PAN_ID = 64'h0123_4567_89AB_CDEF;
  wire logic POLL_ACK, POLL_NOACK, RADIO_DATA_RX, TX_ACK, ORPHAN_RESP, ORPHAN_FAIL, SCAN_VALID, SCAN_DONE;
  wire logic REJOIN_RESP, REJOIN_FAIL, ASSOC_DONE, ASSOC_FAIL, AWAKE, JOINED, POLL_REQ, SAMPLE_SEND;
  wire logic TX_FRAME, TX_DONE, ORPHAN_SCAN, REJOIN_SCAN, REJOIN_REQ, ASSOC_REQ, PARENT_LOST;
  wire logic [63:0] SCAN_PAN_ID;
  wire logic [7:0] ev = {AWAKE, PARENT_LOST, ASSOC_REQ, !AWAKE, JOINED, TX_DONE, SAMPLE_SEND, POLL_REQ};
  int mismatches = 0, check_count = 0, rejoins = 0, samples = 0, n;
  end_device_poll_parent_manager #(.MS_CYCLES(10)) uut (.*);
  parent_model #(.MS(10)) par (.*);
  initial forever #5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (REJOIN_REQ === 1'b1) rejoins++;
    if (SAMPLE_SEND === 1'b1) samples++;
  end
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  // 1 ms is 10 cycles here, so 100 ms is 1000
  task automatic wait_ev(input int s, input int lim, output int k);
    k = 0;
    do begin
      @(posedge MCLK);
      #1;
      k++;
    end while (ev[s] !== 1'b1 && k < lim);
  endtask : wait_ev
  task automatic do_reset();
    @(negedge MCLK);
    RST = 1;
    repeat (4) @(negedge MCLK);
    RST = 0;
  endtask : do_reset
  task automatic t_join();
    do_reset();
    wait_ev(3, 200, n);
    chk(n < 200 && rejoins == 1, "rejoin to own network");
    $display("join test done");
  endtask : t_join
  task automatic t_assoc();
    par.full = 1;
    do_reset();
    rejoins = 0;
    wait_ev(5, 400, n);
    chk(n < 400 && rejoins == 3, "rejoin tries before association");
    wait_ev(3, 20, n);
    chk(n < 20, "join after association");
    @(negedge MCLK);
    JOIN_WINDOW_SETTING = 8'hFF;
    par.full = 0;
    do_reset();
    rejoins = 0;
    wait_ev(5, 100, n);
    chk(n < 100 && rejoins == 0, "direct association");
    $display("association test done");
  endtask : t_assoc
  task automatic t_cyclic();
    wait_ev(0, 3000, n);
    wait_ev(4, 20, n);
    chk(n < 20, "sleep after single poll");
    wait_ev(0, 300, n);
    chk(n > 90 && n < 115, "sleep period length");
    par.pend = 2;
    wait_ev(0, 200, n);
    chk(n > 85 && n < 125, "first fast poll");
    wait_ev(0, 200, n);
    chk(n > 85 && n < 125, "second fast poll");
    wait_ev(0, 1100, n);
    chk(n > 985 && n < 1030, "regular rate after data");
    wait_ev(4, 1100, n);
    chk(n > 860 && n < 940, "sleep at hold expiry");
    $display("cyclic test done");
  endtask : t_cyclic
  task automatic t_sample();
    @(negedge MCLK);
    SAMPLE_INTERVAL_SETTING = 16'h001E;
    EXTRA_IO_LINE_ENABLES = 5'h01;
    WAKE_HOLD_TIMER = 16'h0064;
    samples = 0;
    wait_ev(7, 300, n);
    wait_ev(4, 2000, n);
    chk(samples == 4, "samples per wake");
    @(negedge MCLK);
    EXTRA_IO_LINE_ENABLES = 5'h00;
    samples = 0;
    wait_ev(7, 300, n);
    wait_ev(4, 30, n);
    chk(n < 30 && samples == 0, "no sampling without lines");
    wait_ev(7, 300, n);
    @(negedge MCLK);
    SERIAL_DATA_RX = 1;
    @(negedge MCLK);
    SERIAL_DATA_RX = 0;
    wait_ev(4, 1200, n);
    chk(n > 950 && n < 1030, "serial data holds device awake");
    $display("sample test done");
  endtask : t_sample
  task automatic t_pin();
    bit pat [7] = '{0, 1, 1, 0, 1, 1, 1};
    @(negedge MCLK);
    PIN_SLEEP_MODE = 1;
    SLEEP_REQUEST_PIN = 0;
    // the parent reads a poll one cycle after it shows, so the pattern is set then
    foreach (pat[i]) begin
      wait_ev(0, 1100, n);
      par.drop = pat[i];
      if (i > 0) chk(n > 985 && n < 1030, "pin poll spacing");
    end
    wait_ev(6, 20, n);
    chk(n < 20 && JOINED === 1'b0, "parent lost after misses");
    par.drop = 0;
    wait_ev(3, 200, n);
    chk(n < 200, "new parent found");
    $display("pin test done");
  endtask : t_pin
  task automatic t_tx();
    @(negedge MCLK);
    TX_DATA_REQ = 1;
    @(negedge MCLK);
    TX_DATA_REQ = 0;
    chk(TX_FRAME === 1'b1, "frame sent to parent");
    wait_ev(2, 100, n);
    chk(n > 20 && n < 40, "done follows parent ack");
    $display("transmit test done");
  endtask : t_tx
  // the full 30 s would exceed the run, so only the early hold is seen
  task automatic t_button();
    @(negedge MCLK);
    PIN_SLEEP_MODE = 0;
    SLEEP_REQUEST_PIN = 1;
    SAMPLE_INTERVAL_SETTING = 16'h0000;
    COMMISSIONING_PIN_CONFIG = 1;
    wait_ev(4, 3000, n);
    @(negedge MCLK);
    COMMISSIONING_INPUT_PIN = 0;
    wait_ev(7, 5, n);
    repeat (3000) @(posedge MCLK);
    chk(n < 5 && AWAKE === 1'b1, "button holds device awake");
    $display("button test done");
  endtask : t_button
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    t_join();
    t_assoc();
    t_cyclic();
    t_sample();
    t_pin();
    t_tx();
    t_button();
    print_verdict();
  end
  initial begin
    #600000;
    mismatches++;
    print_verdict();
  end
endmodule : end_device_poll_parent_manager_tb_top
